// File: evs_regs.svh
// Register offsets, field positions, reset values and sizes of the event unit
`ifndef EVS_REGS_SVH
`define EVS_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EVS_OFF_STAT_SEL    12'h000
`define EVS_OFF_STAT_TOTAL  12'h004
`define EVS_OFF_STAT_CLEAR  12'h008
`define EVS_OFF_NOTIFY_EN   12'h00C
`define EVS_OFF_EDGE_SEL    12'h010
`define EVS_OFF_CTRL        12'h014
`define EVS_OFF_INFO_SEL    12'h018
`define EVS_OFF_INFO_IDENT  12'h01C
`define EVS_OFF_INFO_DATA   12'h020
`define EVS_OFF_INFO_TIME   12'h024

// ****************************************************************
// Sizes, fields and reset values
// ****************************************************************
`define EVS_NUM_EVT         18
`define EVS_NUM_STAT        17
`define EVS_NUM_PIN         4
`define EVS_OVF_IDX         17
`define EVS_IDX_W           5
`define EVS_CTRL_DEFER_BIT  0
`define EVS_NOTIFY_RST      18'h00000
`define EVS_EDGE_RST        8'hFF
`define EVS_IDENT_BASE      32'h0000_9000
`define EVS_EDGE_RISE       2'h1
`define EVS_EDGE_FALL       2'h2
`define EVS_EDGE_ANY        2'h3

`endif

// File: evs_pkg.sv
// Types shared by the event and statistics unit
package evs_pkg;

	// Message sender states, one-hot
	typedef enum logic [1:0] {
		EVS_MS_IDLE = 2'h1,
		EVS_MS_SEND = 2'h2
	} evs_msg_state_t;

	// Pin edge choice
	typedef logic [1:0] evs_edge_t;

endpackage

// File: evs_pin_watch.sv
// Input pin synchroniser with selectable edge event
`include "evs_regs.svh"
module evs_pin_watch
	import evs_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Pin and edge choice
	input  wire logic      pin_async,
	input  evs_edge_t      edge_sel,
	// Event strobe
	output logic           change_evt
);

	// ****************************************************************
	// Three-stage synchroniser
	// ****************************************************************
	logic s1_r;     // First stage, read only by s2_r
	logic s2_r;     // Second stage
	logic s3_r;     // Third stage
	logic level_r;  // Accepted pin level
	logic change_r; // Registered event strobe

	// Shift the pin through three flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// ****************************************************************
	// Accepted level and edge event
	// ****************************************************************
	// A change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r  <= 1'b0;
			change_r <= 1'b0;
		end else begin
			change_r <= 1'b0;
			if (s2_r == s3_r && s3_r != level_r) begin
				level_r <= s3_r;
				// Rising, falling or either edge per line
				if (s3_r) begin
					change_r <= edge_sel[0]; // see (R18)
				end else begin
					change_r <= edge_sel[1]; // see (R18)
				end
			end
		end
	end

	assign change_evt = change_r;

	// Rising edge with rising enabled gives one strobe next cycle
	property p_pin_rise;
		@(posedge pclk) disable iff (!presetn)
		(s2_r && s3_r && !level_r && edge_sel[0]) |=> change_evt;
	endproperty
	a_pin_rise: assert property (p_pin_rise) // see (R18)
		else $error("rising pin edge gave no event");

endmodule

// File: evs_top.sv
// Event source, notification sender and occurrence statistics
//
// Overview of operation
// (R1) Selector chooses which source count is shown
// (R2) Selected source occurrence total is readable
// (R3) Clear write zeroes only selected counter
// (R4) Events for capture begin and finish
// (R5) Frame begin event at exposure delay start
// (R6) Frame finish event at frame end
// (R7) Accepted frame trigger raises event
// (R8) Refused frame trigger: no frame, event raised
// (R9) Dropped image raises event
// (R10) Refused undeferred line trigger raises event
// (R11) Deferred line trigger raises event
// (R12) Input pins a-d change events
// (R13) Output pins c-f pulse start events
// (R14) Each event type has fixed readable ident
// (R15) Timestamp captured when event is raised
// (R16) Each event type has readable data word
// (R17) Per-type notify enable; disabled sends nothing
// (R18) Pin event edge chosen per line
// (R19) Overrun disables all types, raises overrun event; the overrun type itself stays enabled
// (R20) Counters count always and saturate
`include "evs_regs.svh"
module evs_top
	import evs_pkg::*;
#(
	parameter int CNT_W = 32, // Occurrence counter width
	parameter int TS_W  = 32  // Timestamp width
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Event strobes from camera logic
	input  wire logic         capture_begin_evt,
	input  wire logic         capture_finish_evt,
	input  wire logic         frame_begin_evt,
	input  wire logic         frame_finish_evt,
	input  wire logic         frame_dropped_evt,
	// Triggers
	input  wire logic         frame_trig,
	input  wire logic         line_trig,
	input  wire logic         trig_permitted,
	output logic              frame_acq_start,
	output logic              line_acq_start,
	// Pins
	input  wire logic [3:0]   input_pin,
	input  wire logic [3:0]   out_pin_pulse,
	// Notification channel
	output logic              msg_valid,
	input  wire logic         msg_ready,
	output logic [31:0]       msg_ident,
	output logic [31:0]       msg_payload,
	output logic [TS_W-1:0]   msg_time
);

	localparam int NE = `EVS_NUM_EVT;
	localparam int NS = `EVS_NUM_STAT;

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [4:0]             stat_source_select_r; // Statistic selector
	logic [NE-1:0]          notify_enable_r;      // Per-type enables
	logic [7:0]             pin_edge_select_r;    // Two bits per pin
	logic                   defer_en_r;           // Line trigger deferral
	logic [4:0]             info_sel_r;           // Info readback index
	logic [TS_W-1:0]        ts_r;                 // Free running time
	logic [CNT_W-1:0]       cnt_r [NS];           // Occurrence totals
	logic [TS_W-1:0]        time_r [NE];          // Last event time
	logic [31:0]            data_r [NE];          // Last event data
	logic [NE-1:0]          pend_r;               // Awaiting send
	logic                   hold_r;               // Deferred line trig
	logic [3:0]             out_q_r;              // Pulse level history
	logic [3:0]             pin_evt;              // Pin change strobes
	logic [NE-1:0]          ev;                   // All event strobes
	logic [NE-1:0]          sent;                 // Sent this cycle
	logic                   ovf;                  // Send overrun
	logic [4:0]             msg_idx_r;            // Index being sent
	evs_msg_state_t         ms_r;                 // Sender state
	logic                   wr_acc;               // APB write access
	logic                   rd_setup;             // APB read setup
	logic                   clr_stat;             // Clear command

	// ****************************************************************
	// Event sources
	// ****************************************************************
	// Input pin watchers
	genvar gp;
	generate
		for (gp = 0; gp < `EVS_NUM_PIN; gp++) begin : g_pin
			evs_pin_watch u_pin (
				.pclk       (pclk),
				.presetn    (presetn),
				.pin_async  (input_pin[gp]),
				.edge_sel   (pin_edge_select_r[2*gp +: 2]),
				.change_evt (pin_evt[gp])
			);
		end
	endgenerate

	// Gather the strobes in source order
	always_comb begin
		ev      = '0;
		ev[0]   = capture_begin_evt;                 // see (R4)
		ev[1]   = capture_finish_evt;                // see (R4)
		ev[2]   = frame_begin_evt;                   // see (R5)
		ev[3]   = frame_finish_evt;                  // see (R6)
		ev[4]   = frame_trig & trig_permitted;       // see (R7)
		ev[5]   = frame_trig & ~trig_permitted;      // see (R8)
		ev[6]   = frame_dropped_evt;                 // see (R9)
		ev[7]   = line_trig & ~trig_permitted & ~defer_en_r; // see (R10)
		ev[8]   = line_trig & ~trig_permitted & defer_en_r;  // see (R11)
		ev[12:9]  = pin_evt;                         // see (R12)
		ev[16:13] = out_pin_pulse & ~out_q_r;        // see (R13)
		ev[`EVS_OVF_IDX] = ovf;                      // see (R19)
	end

	// Trigger outcome and output pulse history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_acq_start <= 1'b0;
			line_acq_start  <= 1'b0;
			hold_r          <= 1'b0;
			out_q_r         <= 4'h0;
		end else begin
			out_q_r         <= out_pin_pulse;
			// Refused frame triggers start nothing
			frame_acq_start <= frame_trig & trig_permitted; // see (R8)
			line_acq_start  <= trig_permitted & (line_trig | hold_r);
			// Postpone refused line trigger; a new one wins over release
			if (ev[8]) begin
				hold_r <= 1'b1; // see (R11)
			end else if (trig_permitted) begin
				hold_r <= 1'b0;
			end
		end
	end

	// Timestamp base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_r <= '0;
		end else begin
			ts_r <= ts_r + 1'b1;
		end
	end

	// ****************************************************************
	// Occurrence counters, times and data
	// ****************************************************************
	genvar gc;
	generate
		for (gc = 0; gc < NE; gc++) begin : g_evt
			// Time and data of the latest occurrence
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					time_r[gc] <= '0;
					data_r[gc] <= 32'h0;
				end else if (ev[gc]) begin
					time_r[gc] <= ts_r; // see (R15)
					if (gc == `EVS_OVF_IDX) begin
						data_r[gc] <= 32'(notify_enable_r); // see (R16)
					end else begin
						data_r[gc] <= 32'(ts_r); // see (R16)
					end
				end
			end
			if (gc < NS) begin : g_cnt
				// Count always; clear and count together leave one
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						cnt_r[gc] <= '0;
					end else if (clr_stat && stat_source_select_r == gc) begin
						cnt_r[gc] <= CNT_W'(ev[gc]); // see (R3)
					end else if (ev[gc] && ~&cnt_r[gc]) begin
						cnt_r[gc] <= cnt_r[gc] + 1'b1; // see (R20)
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Notification sender
	// ****************************************************************
	// Same type again before its last one left means overrun
	assign ovf  = |(ev[NS-1:0] & pend_r[NS-1:0] & notify_enable_r[NS-1:0]
		& ~sent[NS-1:0]); // see (R19)
	assign sent = (ms_r == EVS_MS_SEND && msg_ready) ?
		(NE'(1) << msg_idx_r) : '0;

	// Pending set by enabled events only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= '0;
		end else begin
			pend_r <= (pend_r & ~sent) | (ev & notify_enable_r); // see (R17)
		end
	end

	// Pick lowest pending type, hold the message until taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_r        <= EVS_MS_IDLE;
			msg_idx_r   <= 5'h0;
			msg_ident   <= 32'h0;
			msg_payload <= 32'h0;
			msg_time    <= '0;
		end else begin
			case (ms_r)
				EVS_MS_IDLE: begin
					for (int i = NE - 1; i >= 0; i--) begin
						if (pend_r[i]) begin
							msg_idx_r   <= 5'(i);
							msg_ident   <= `EVS_IDENT_BASE + 32'(i); // see (R14)
							msg_payload <= data_r[i];
							msg_time    <= time_r[i];
							ms_r        <= EVS_MS_SEND;
						end
					end
				end
				EVS_MS_SEND: begin
					if (msg_ready) begin
						ms_r <= EVS_MS_IDLE;
					end
				end
				default: begin
					ms_r <= EVS_MS_IDLE;
				end
			endcase
		end
	end

	assign msg_valid = (ms_r == EVS_MS_SEND);

	// ****************************************************************
	// APB registers
	// ****************************************************************
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign clr_stat = wr_acc && paddr == `EVS_OFF_STAT_CLEAR;
	assign pready   = 1'b1;

	// Unmapped offset answers with an error
	always_comb begin
		pslverr = psel & penable;
		if (paddr == `EVS_OFF_STAT_SEL || paddr == `EVS_OFF_STAT_TOTAL
			|| paddr == `EVS_OFF_STAT_CLEAR || paddr == `EVS_OFF_NOTIFY_EN
			|| paddr == `EVS_OFF_EDGE_SEL || paddr == `EVS_OFF_CTRL
			|| paddr == `EVS_OFF_INFO_SEL || paddr == `EVS_OFF_INFO_IDENT
			|| paddr == `EVS_OFF_INFO_DATA
			|| paddr == `EVS_OFF_INFO_TIME) begin
			pslverr = 1'b0;
		end
	end

	// Writable controls; overrun clearing of enables wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_source_select_r <= 5'h0;
			notify_enable_r      <= `EVS_NOTIFY_RST;
			pin_edge_select_r    <= `EVS_EDGE_RST;
			defer_en_r           <= 1'b0;
			info_sel_r           <= 5'h0;
		end else begin
			if (wr_acc) begin
				if (paddr == `EVS_OFF_STAT_SEL) begin
					stat_source_select_r <= pwdata[4:0]; // see (R1)
				end else if (paddr == `EVS_OFF_NOTIFY_EN) begin
					notify_enable_r <= pwdata[NE-1:0]; // see (R17)
				end else if (paddr == `EVS_OFF_EDGE_SEL) begin
					pin_edge_select_r <= pwdata[7:0]; // see (R18)
				end else if (paddr == `EVS_OFF_CTRL) begin
					defer_en_r <= pwdata[`EVS_CTRL_DEFER_BIT];
				end else if (paddr == `EVS_OFF_INFO_SEL) begin
					info_sel_r <= pwdata[4:0];
				end
			end
			if (ovf) begin
				notify_enable_r[NS-1:0] <= '0; // see (R19)
			end
		end
	end

	// Read data captured in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= 32'h0;
			if (paddr == `EVS_OFF_STAT_SEL) begin
				prdata <= 32'(stat_source_select_r);
			end else if (paddr == `EVS_OFF_STAT_TOTAL) begin
				if (stat_source_select_r < 5'(NS)) begin
					prdata <= 32'(cnt_r[stat_source_select_r]); // see (R2)
				end
			end else if (paddr == `EVS_OFF_NOTIFY_EN) begin
				prdata <= 32'(notify_enable_r);
			end else if (paddr == `EVS_OFF_EDGE_SEL) begin
				prdata <= 32'(pin_edge_select_r);
			end else if (paddr == `EVS_OFF_CTRL) begin
				prdata <= 32'(defer_en_r);
			end else if (paddr == `EVS_OFF_INFO_SEL) begin
				prdata <= 32'(info_sel_r);
			end else if (info_sel_r < 5'(NE)) begin
				if (paddr == `EVS_OFF_INFO_IDENT) begin
					prdata <= `EVS_IDENT_BASE + 32'(info_sel_r); // see (R14)
				end else if (paddr == `EVS_OFF_INFO_DATA) begin
					prdata <= data_r[info_sel_r]; // see (R16)
				end else if (paddr == `EVS_OFF_INFO_TIME) begin
					prdata <= 32'(time_r[info_sel_r]); // see (R15)
				end
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_frame_accept;
		@(posedge pclk) disable iff (!presetn)
		(frame_trig && trig_permitted) |=> frame_acq_start;
	endproperty
	a_frame_accept: assert property (p_frame_accept) // see (R7)
		else $error("accepted frame trigger started no frame");

	property p_frame_refuse;
		@(posedge pclk) disable iff (!presetn)
		(frame_trig && !trig_permitted) |=> !frame_acq_start
			&& (cnt_r[5] != $past(cnt_r[5]) || &$past(cnt_r[5]));
	endproperty
	a_frame_refuse: assert property (p_frame_refuse) // see (R8)
		else $error("refused frame trigger mishandled");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(clr_stat && stat_source_select_r == 5'h0 && !ev[0])
			|=> cnt_r[0] == '0;
	endproperty
	a_clear: assert property (p_clear) // see (R3)
		else $error("selected total not cleared");

	property p_count;
		@(posedge pclk) disable iff (!presetn)
		(ev[1] && !clr_stat && !(&cnt_r[1]))
			|=> cnt_r[1] == $past(cnt_r[1]) + 1'b1;
	endproperty
	a_count: assert property (p_count) // see (R20)
		else $error("occurrence not counted");

	property p_overrun;
		@(posedge pclk) disable iff (!presetn)
		ovf |=> notify_enable_r[NS-1:0] == '0 ##1 msg_valid [*1] or
			notify_enable_r[NS-1:0] == '0 ##[1:40] msg_valid;
	endproperty
	a_overrun: assert property (p_overrun) // see (R19)
		else $error("overrun left enables set or no message");

	property p_defer;
		@(posedge pclk) disable iff (!presetn)
		(line_trig && !trig_permitted && defer_en_r) ##1 trig_permitted
			|=> line_acq_start;
	endproperty
	a_defer: assert property (p_defer) // see (R11)
		else $error("deferred line trigger never released");

	property p_time;
		@(posedge pclk) disable iff (!presetn)
		ev[0] |=> time_r[0] == $past(ts_r);
	endproperty
	a_time: assert property (p_time) // see (R15)
		else $error("timestamp not captured");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(msg_valid && !msg_ready) |=> msg_valid && $stable(msg_ident)
			&& $stable(msg_time);
	endproperty
	a_hold: assert property (p_hold) // see (R14)
		else $error("message changed before taken");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn)
		(ev[2] && !notify_enable_r[2] && !pend_r[2]) |=> !pend_r[2];
	endproperty
	a_disabled: assert property (p_disabled) // see (R17)
		else $error("disabled type queued a message");

endmodule

// File: evs_host_sink.sv
// Host side message sink with prompt, slow and held acceptance
module evs_host_sink (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Pace: 0 prompt, 1 slow, 2 held
	input  wire logic [1:0] mode,
	// Message channel
	input  wire logic       msg_valid,
	output logic            msg_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] phase_r; // Slow pace divider

	// Free running divider for the slow pace
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) phase_r <= 2'h0;
		else phase_r <= phase_r + 2'h1;
	end

	// Ready on a quarter of the cycles when slow, never when held
	assign msg_ready = (mode == 2'h0) || (mode == 2'h1 && phase_r == 2'h3);
endmodule

// File: event_statistics_counter_bench.sv
// Self-checking bench of the event and statistics unit
`include "evs_regs.svh"
module event_statistics_counter_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Signals and scoreboard
	// ************************************************************
	logic        pclk, presetn, psel, penable, pwrite; // Clock, reset, APB
	logic [11:0] paddr;                                // APB address
	logic [31:0] pwdata, prdata;                       // APB data
	logic        pready, pslverr;                      // APB answer
	logic [4:0]  ev;                  // Direct event strobes
	logic        frame_trig, line_trig, trig_permitted; // Triggers
	logic        frame_acq_start, line_acq_start;       // Trigger results
	logic [3:0]  input_pin, out_pin_pulse;             // Pins
	logic        msg_valid, msg_ready;                 // Message handshake
	logic [31:0] msg_ident, msg_payload, msg_time;     // Message fields
	logic [1:0]  sink_mode;           // Host acceptance pace
	logic [96:0] exp_q[$];            // Expected: flag, ident, data, time
	logic [96:0] mx;                  // Message taken off the queue
	logic [31:0] tnow, t_last;        // Bench time base, last event time
	logic [31:0] cnt[17];             // Expected occurrence totals
	logic [31:0] seed, rq;            // Random state, read data
	logic        re;                  // Read error flag
	int          n_errors, n_checks;  // Counters
	int          k;                   // Random clear target

	evs_top #(.CNT_W(32), .TS_W(32)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.capture_begin_evt(ev[0]), .capture_finish_evt(ev[1]),
		.frame_begin_evt(ev[2]), .frame_finish_evt(ev[3]),
		.frame_dropped_evt(ev[4]), .frame_trig(frame_trig),
		.line_trig(line_trig), .trig_permitted(trig_permitted),
		.frame_acq_start(frame_acq_start), .line_acq_start(line_acq_start),
		.input_pin(input_pin), .out_pin_pulse(out_pin_pulse),
		.msg_valid(msg_valid), .msg_ready(msg_ready),
		.msg_ident(msg_ident), .msg_payload(msg_payload),
		.msg_time(msg_time));

	evs_host_sink u_sink (.pclk(pclk), .presetn(presetn), .mode(sink_mode),
		.msg_valid(msg_valid), .msg_ready(msg_ready));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Free running time, zero while in reset, one step per rising edge
	always @(posedge pclk) begin
		tnow <= presetn ? tnow + 32'h1 : 32'h0;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			$display("mismatch pready expected 1 seen 0");
			n_errors++;
			give_verdict();
		end
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rq);
	endtask

	// Reads every occurrence total through the selector
	task check_stats();
		for (int i = 0; i < 17; i++) begin
			apb(1'b1, `EVS_OFF_STAT_SEL, i);
			rd(`EVS_OFF_STAT_TOTAL, cnt[i], "stat_total");
		end
	endtask

	// Raises source i; c: counted, s: message expected
	task fire(input int i, input logic c, input logic s);
		@(posedge pclk);
		case (i)
			4, 5: begin
				trig_permitted <= (i == 4);
				frame_trig <= 1'b1;
			end
			7, 8: begin
				trig_permitted <= 1'b0;
				line_trig <= 1'b1;
			end
			9, 10, 11, 12: input_pin[i-9] <= ~input_pin[i-9];
			13, 14, 15, 16: out_pin_pulse[i-13] <= 1'b1;
			default: ev[(i == 6) ? 4 : i] <= 1'b1;
		endcase
		if (c) cnt[i] = cnt[i] + 32'h1;
		// Pins take five edges through sync and stability, others one
		t_last = tnow + ((i >= 9 && i <= 12) ? 32'h5 : 32'h1);
		if (s) exp_q.push_back({1'b0, `EVS_IDENT_BASE + i, 32'h0, t_last});
		@(posedge pclk);
		ev <= 5'h00;
		frame_trig <= 1'b0;
		line_trig <= 1'b0;
		out_pin_pulse <= 4'h0;
		if (i == 8) trig_permitted <= 1'b1;
		@(negedge pclk);
		if (i == 4 || i == 5) begin
			chk("frame_acq_start", i == 4, frame_acq_start);
		end
		@(posedge pclk);
		@(negedge pclk);
		if (i == 7 || i == 8) begin
			chk("line_acq_start", i == 8, line_acq_start);
		end
		repeat (12) @(posedge pclk);
	endtask

	// ************************************************************
	// Message watcher: compares each accepted message to the oldest note
	// ************************************************************
	always @(posedge pclk) begin
		if (presetn && msg_valid === 1'b1 && msg_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("msg_extra", 32'h0, 32'h1);
			end else begin
				mx = exp_q.pop_front();
				chk("msg_ident", mx[95:64], msg_ident);
				chk("msg_time", mx[31:0], msg_time);
				if (mx[96]) begin
					chk("msg_payload", mx[63:32], msg_payload);
				end else begin
					chk("msg_payload", mx[31:0], msg_payload);
				end
			end
		end
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge pclk);
		$display("mismatch watchdog expected 0 seen 1");
		n_errors++;
		give_verdict();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ev = 5'h00;
		frame_trig = 1'b0;
		line_trig = 1'b0;
		trig_permitted = 1'b1;
		input_pin = 4'h0;
		out_pin_pulse = 4'h0;
		sink_mode = 2'h0;
		n_errors = 0;
		n_checks = 0;
		seed = 32'h57FC1063;
		foreach (cnt[j]) cnt[j] = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped place and identifiers
		rd(`EVS_OFF_NOTIFY_EN, `EVS_NOTIFY_RST, "notify_en");
		rd(`EVS_OFF_EDGE_SEL, `EVS_EDGE_RST, "edge_sel");
		rd(12'h3FC, 32'h0, "unmapped_data");
		chk("unmapped_err", 32'h1, re);
		for (int i = 0; i < 18; i++) begin
			apb(1'b1, `EVS_OFF_INFO_SEL, i);
			rd(`EVS_OFF_INFO_IDENT, `EVS_IDENT_BASE + i, "info_ident");
		end
		$display("test reset and identifiers done");
		// Every source once, host accepting slowly
		sink_mode <= 2'h1;
		apb(1'b1, `EVS_OFF_NOTIFY_EN, 32'h0001_FFFF);
		for (int i = 0; i < 17; i++) begin
			apb(1'b1, `EVS_OFF_CTRL, i == 8);
			fire(i, 1'b1, 1'b1);
		end
		$display("test all sources done");
		// Rising edge only on pin a, out pin c not enabled
		apb(1'b1, `EVS_OFF_EDGE_SEL, 32'h55);
		apb(1'b1, `EVS_OFF_NOTIFY_EN, 32'h0000_0200);
		fire(9, 1'b0, 1'b0);
		fire(9, 1'b1, 1'b1);
		// Falling edge only: 1 to 0 counts, 0 to 1 does not
		apb(1'b1, `EVS_OFF_EDGE_SEL, 32'hAA);
		fire(9, 1'b1, 1'b1);
		fire(9, 1'b0, 1'b0);
		fire(13, 1'b1, 1'b0);
		// Time and data of the last pulse read back
		apb(1'b1, `EVS_OFF_INFO_SEL, 32'hD);
		rd(`EVS_OFF_INFO_TIME, t_last, "info_time");
		rd(`EVS_OFF_INFO_DATA, t_last, "info_data");
		$display("test edge choice and enables done");
		// Totals, then clear one chosen at random
		check_stats();
		seed = lfsr(seed);
		k = seed % 17;
		apb(1'b1, `EVS_OFF_STAT_SEL, k);
		apb(1'b1, `EVS_OFF_STAT_CLEAR, seed);
		cnt[k] = 32'h0;
		check_stats();
		$display("test statistics done");
		// Repeat while the first message is held: overrun
		sink_mode <= 2'h2;
		apb(1'b1, `EVS_OFF_NOTIFY_EN, 32'h0002_0001);
		fire(0, 1'b1, 1'b1);
		fire(0, 1'b1, 1'b0);
		exp_q.push_back({1'b1, `EVS_IDENT_BASE + `EVS_OVF_IDX,
			32'h0002_0001, t_last});
		rd(`EVS_OFF_NOTIFY_EN, 32'h0002_0000, "notify_overrun");
		sink_mode <= 2'h0;
		repeat (20) @(posedge pclk);
		chk("msg_left", 32'h0, exp_q.size());
		check_stats();
		$display("test overrun done");
		give_verdict();
	end
endmodule
